// *** inc/snbe_pkg.sv ***
package snbe_pkg;
  // =====================================================================
  // instruction codes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_REMAP  = 8'ha1;
  localparam logic [7:0] OP_LUTRD  = 8'ha5;
  localparam logic [7:0] OP_FAILPG = 8'ha9;
  localparam logic [7:0] OP_ERASE  = 8'hd8;
  localparam logic [7:0] OP_STAT_A = 8'h0f;
  localparam logic [7:0] OP_STAT_B = 8'h05;
  // =====================================================================
  // frame lengths in serial clocks
  localparam logic [9:0] OPC_BITS   = 10'h008;
  localparam logic [9:0] ERASE_BITS = 10'h020;
  localparam logic [9:0] REMAP_BITS = 10'h028;
  localparam logic [9:0] OUT_START  = 10'h010;
  localparam logic [9:0] CNT_MAX    = 10'h3ff;
  // =====================================================================
  // remap table and array geometry
  localparam int         LINKS       = 20;
  localparam logic [4:0] LINKS_W     = 5'h14;
  localparam int         PAGE_BLK_LSB = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int         PROT_ALL    = 11;
  // =====================================================================
  // timing
  localparam int CLK_MHZ       = 100;
  localparam int ERASE_TIME_US = 2000;
  localparam int REMAP_TIME_US = 250;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int REMAP_CYCLES  = REMAP_TIME_US * CLK_MHZ;
  // =====================================================================
  // reset values
  localparam logic       ECC_ON_RST = 1'b1;
  localparam logic [1:0] ECC_CLEAN  = 2'h0;

  typedef struct packed {
    logic       tableFull;
    logic       rsvd6;
    logic [1:0] eccStat;
    logic       rsvd3;
    logic       eraseFail;
    logic       write_permit_latch;
    logic       busy;
  } snbe_status_t;

  typedef struct packed {
    logic        enable;
    logic        invalid;
    logic [13:0] logAddr;
    logic [15:0] physAddr;
  } snbe_link_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_REMAP
  } snbe_state_t;
endpackage : snbe_pkg

// *** verilog/snbe_core.sv ***
// Behaviour
// - flag a block bad when page-0 byte 0 or spare byte 0 is not FFh.
// - remap frame is A1h, 16-bit logical then 16-bit physical block address.
// - remap accepted only while write permit latch is set.
// - accepted remap appends the link to the 20-entry table.
// - after 20 links the table full flag is set; more remaps refused.
// - table read is A5h plus 8 dummies; links shift out from clock 16.
// - links come out from link 0 onward; unused links read zero.
// - logical word bits 15:14 carry enable and invalid link state.
// - correction enable, default 1, turns ECC on for program and read.
// - program with ECC on stores parity in the spare area.
// - reads update the two correction status bits.
// - status codes 10 or 11 mean an uncorrectable page was read.
// - A9h plus 8 dummies returns last uncorrectable page address.
// - block erase sets the whole 64-page block to FFh.
// - erase accepted only while write permit latch is set.
// - erase frame is D8h, 8 dummies, 16-bit page address.
// - erase discarded unless chip select rises right after bit 32.
// - self-timed erase keeps busy high; status reads still work.
// - finished erase clears the write permit latch.
// - erase skipped when the block lies in the protected region.
// - completed remap clears the write permit latch.
// - write enable 06h sets the latch at chip select rise.
// - status read 0Fh or 05h served at any time, even when busy.
`timescale 1ns/1ns
`default_nettype none
module snbe_core #(
  parameter int ERASE_CYC = snbe_pkg::ERASE_CYCLES,
  parameter int REMAP_CYC = snbe_pkg::REMAP_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        spiClk,
  input  wire logic        csN,
  input  wire logic        serialIn,
  output var  logic        serialOut,
  output var  logic        serialOutEn,
  input  wire logic        eccEnable,
  input  wire logic        protect_top_bottom,
  input  wire logic [3:0]  protect_level_bits,
  input  wire logic        readDone,
  input  wire logic [1:0]  readEccResult,
  input  wire logic [15:0] readPage,
  input  wire logic        markerValid,
  input  wire logic [7:0]  markerMain,
  input  wire logic [7:0]  markerSpare,
  output var  logic        badBlockMark,
  output var  logic        eccActive,
  output var  logic        eraseStart,
  output var  logic [9:0]  eraseBlock,
  output var  logic        busy,
  output var  logic        table_full_flag
);

  // =====================================================================
  // link domain: bit capture on the rising serial clock
  // chip select high clears the frame counter; captured words are kept
  // so the system side can read them while the serial clock is idle
  wire logic spiRst_n;
  assign spiRst_n = rst_n & ~csN;

  logic [9:0]  bitCnt_r;
  logic [9:0]  cmdBits_r;
  logic [7:0]  opcode_r;
  logic [31:0] arg_r;
  wire  logic [9:0] bitCntInc;
  assign bitCntInc = (bitCnt_r == snbe_pkg::CNT_MAX) ? bitCnt_r
                                                     : bitCnt_r + 10'h001;

  always_ff @(posedge spiClk or negedge spiRst_n) begin
    if (!spiRst_n) bitCnt_r <= 10'h000;
    else           bitCnt_r <= bitCntInc;
  end

  always_ff @(posedge spiClk or negedge rst_n) begin
    if (!rst_n) begin
      cmdBits_r <= 10'h000;
      opcode_r  <= 8'h00;
      arg_r     <= 32'h0000_0000;
    end else begin
      cmdBits_r <= bitCntInc;
      if (bitCnt_r < snbe_pkg::OPC_BITS)
        opcode_r <= {opcode_r[6:0], serialIn};
      else
        arg_r <= {arg_r[30:0], serialIn};
    end
  end

  // =====================================================================
  // link domain: status and failing page brought over by two flops
  // bits are independent levels; a page word caught mid-change is only
  // possible when a read completes during the very same query frame
  snbe_pkg::snbe_status_t status_r;
  logic [15:0]            lastFailPage_r;
  logic [23:0]            toLinkS1_r;
  logic [23:0]            toLinkS2_r;

  always_ff @(posedge spiClk or negedge rst_n) begin
    if (!rst_n) begin
      toLinkS1_r <= 24'h00_0000;
      toLinkS2_r <= 24'h00_0000;
    end else begin
      toLinkS1_r <= {status_r, lastFailPage_r};
      toLinkS2_r <= toLinkS1_r;
    end
  end

  wire snbe_pkg::snbe_status_t linkStat;
  wire logic [15:0]            linkFailPage;
  assign linkStat     = toLinkS2_r[23:16];
  assign linkFailPage = toLinkS2_r[15:0];

  // =====================================================================
  // link domain: output selection, driven on the falling serial clock
  snbe_pkg::snbe_link_t lut_r [snbe_pkg::LINKS];

  wire logic [9:0] outIdx;
  wire logic       isStat;
  wire logic       isLut;
  wire logic       isFail;
  wire logic       outAllowed;
  wire logic [4:0] linkSel;
  wire logic [31:0] linkWord;
  wire logic       outBit;
  assign outIdx  = bitCnt_r - snbe_pkg::OUT_START;
  assign isStat  = (opcode_r == snbe_pkg::OP_STAT_A) ||
                   (opcode_r == snbe_pkg::OP_STAT_B);
  assign isLut   = opcode_r == snbe_pkg::OP_LUTRD;
  assign isFail  = opcode_r == snbe_pkg::OP_FAILPG;
  assign outAllowed = (bitCnt_r >= snbe_pkg::OUT_START) &&
                      (isStat || (!linkStat.busy && (isLut || isFail)));
  assign linkSel  = outIdx[9:5];
  // slots past the last link and unused slots both shift out zero
  assign linkWord = (linkSel < snbe_pkg::LINKS_W) ?
                    lut_r[linkSel] : 32'h0000_0000;
  assign outBit   = isStat ? linkStat[3'h7 - outIdx[2:0]] :
                    isLut  ? linkWord[5'h1f - outIdx[4:0]] :
                    (outIdx < 10'h010) ?
                      linkFailPage[4'hf - outIdx[3:0]] : 1'b0;

  always_ff @(negedge spiClk or negedge spiRst_n) begin
    if (!spiRst_n) begin
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
    end else begin
      serialOut   <= outAllowed & outBit;
      serialOutEn <= outAllowed;
    end
  end

  // =====================================================================
  // system domain: chip select synchroniser and frame end detect
  logic csS1_r;
  logic csS2_r;
  logic csPrev_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      csS1_r   <= 1'b1;
      csS2_r   <= 1'b1;
      csPrev_r <= 1'b1;
    end else if (clkEn) begin
      csS1_r   <= csN;
      csS2_r   <= csS1_r;
      csPrev_r <= csS2_r;
    end
  end

  // captured words are static here: the serial clock only runs while
  // chip select is low, and this pulse comes after it has gone high
  wire logic frameEnd;
  assign frameEnd = csS2_r & ~csPrev_r;

  // =====================================================================
  // system domain: protection decode
  function automatic logic blockProtected(input logic       top,
                                          input logic [3:0] level,
                                          input logic [9:0] blk);
    logic [10:0] span;
    span = 11'h000;
    if (level != 4'h0)
      span = 11'h001 << (level - 4'h1);
    if (level == 4'h0)
      blockProtected = 1'b0;
    else if (int'(level) >= snbe_pkg::PROT_ALL)
      blockProtected = 1'b1;
    else if (top)
      blockProtected = {1'b0, blk} >= (11'h400 - span);
    else
      blockProtected = {1'b0, blk} < span;
  endfunction : blockProtected

  // =====================================================================
  // system domain: command decode at frame end
  snbe_pkg::snbe_state_t state_r;
  logic [4:0]            linkCount_r;
  logic                  wel_r;

  wire logic       idle;
  wire logic       full;
  wire logic [9:0] argBlock;
  wire logic       doWren;
  wire logic       doWrdi;
  wire logic       doRemap;
  wire logic       doErase;
  wire logic       eraseProt;
  assign idle     = state_r == snbe_pkg::ST_IDLE;
  assign full     = linkCount_r == snbe_pkg::LINKS_W;
  assign argBlock = arg_r[15:snbe_pkg::PAGE_BLK_LSB];
  assign eraseProt = blockProtected(protect_top_bottom,
                                    protect_level_bits, argBlock);
  assign doWren  = frameEnd && idle &&
                   opcode_r == snbe_pkg::OP_WREN &&
                   cmdBits_r == snbe_pkg::OPC_BITS;
  assign doWrdi  = frameEnd && idle &&
                   opcode_r == snbe_pkg::OP_WRDI &&
                   cmdBits_r == snbe_pkg::OPC_BITS;
  assign doRemap = frameEnd && idle && wel_r && !full &&
                   opcode_r == snbe_pkg::OP_REMAP &&
                   cmdBits_r == snbe_pkg::REMAP_BITS;
  assign doErase = frameEnd && idle && wel_r &&
                   opcode_r == snbe_pkg::OP_ERASE &&
                   cmdBits_r == snbe_pkg::ERASE_BITS;

  // =====================================================================
  // system domain: sequencer and self-timed wait
  logic [31:0] timer_r;
  wire  logic  timerDone;
  assign timerDone = timer_r == 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= snbe_pkg::ST_IDLE;
      timer_r <= 32'h0000_0000;
    end else if (clkEn) begin
      case (state_r)
        snbe_pkg::ST_IDLE: begin
          if (doErase && !eraseProt) begin
            state_r <= snbe_pkg::ST_ERASE;
            timer_r <= 32'(ERASE_CYC - 1);
          end else if (doRemap) begin
            state_r <= snbe_pkg::ST_REMAP;
            timer_r <= 32'(REMAP_CYC - 1);
          end
        end
        snbe_pkg::ST_ERASE,
        snbe_pkg::ST_REMAP: begin
          if (timerDone) state_r <= snbe_pkg::ST_IDLE;
          else           timer_r <= timer_r - 32'h0000_0001;
        end
        default: state_r <= snbe_pkg::ST_IDLE;
      endcase
    end
  end

  wire logic eraseFinish;
  wire logic remapFinish;
  assign eraseFinish = state_r == snbe_pkg::ST_ERASE && timerDone;
  assign remapFinish = state_r == snbe_pkg::ST_REMAP && timerDone;

  // =====================================================================
  // system domain: write permit latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)                    wel_r <= 1'b0;
    else if (clkEn) begin
      if (doWren)                  wel_r <= 1'b1;
      else if (doWrdi)             wel_r <= 1'b0;
      else if (eraseFinish)        wel_r <= 1'b0;
      else if (remapFinish)        wel_r <= 1'b0;
    end
  end

  // =====================================================================
  // system domain: remap table
  // held in flops from reset; a real part keeps it across power loss
  logic [15:0] pendLog_r;
  logic [15:0] pendPhys_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pendLog_r  <= 16'h0000;
      pendPhys_r <= 16'h0000;
    end else if (clkEn && doRemap) begin
      pendLog_r  <= arg_r[31:16];
      pendPhys_r <= arg_r[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)                      linkCount_r <= 5'h00;
    else if (clkEn && remapFinish)   linkCount_r <= linkCount_r + 5'h01;
  end

  genvar gi;
  generate
    for (gi = 0; gi < snbe_pkg::LINKS; gi++) begin : gLink
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
          lut_r[gi] <= '0;
        else if (clkEn && remapFinish && linkCount_r == 5'(gi)) begin
          lut_r[gi].enable   <= 1'b1;
          lut_r[gi].invalid  <= 1'b0;
          lut_r[gi].logAddr  <= pendLog_r[13:0];
          lut_r[gi].physAddr <= pendPhys_r;
        end
      end
    end
  endgenerate

  // =====================================================================
  // system domain: correction status and failing page
  logic [1:0] eccStat_r;
  logic       eraseFail_r;
  wire  logic uncorr;
  assign uncorr = readDone && eccActive && readEccResult[1];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eccStat_r      <= snbe_pkg::ECC_CLEAN;
      lastFailPage_r <= 16'h0000;
      eccActive      <= snbe_pkg::ECC_ON_RST;
    end else if (clkEn) begin
      eccActive <= eccEnable;
      if (readDone && eccActive) eccStat_r <= readEccResult;
      if (uncorr)                lastFailPage_r <= readPage;
    end
  end

  // =====================================================================
  // system domain: outputs and status image
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eraseStart      <= 1'b0;
      eraseBlock      <= 10'h000;
      eraseFail_r     <= 1'b0;
      busy            <= 1'b0;
      table_full_flag <= 1'b0;
      badBlockMark    <= 1'b0;
      status_r        <= '0;
    end else if (clkEn) begin
      // erase engine fills the block with ERASED_BYTE
      eraseStart <= doErase && !eraseProt;
      if (doErase) begin
        eraseBlock  <= argBlock;
        eraseFail_r <= eraseProt;
      end
      busy            <= !idle;
      table_full_flag <= full;
      if (markerValid)
        badBlockMark <= (markerMain != snbe_pkg::ERASED_BYTE) ||
                        (markerSpare != snbe_pkg::ERASED_BYTE);
      status_r.tableFull <= full;
      status_r.rsvd6     <= 1'b0;
      status_r.eccStat   <= eccStat_r;
      status_r.rsvd3     <= 1'b0;
      status_r.eraseFail <= eraseFail_r;
      status_r.write_permit_latch       <= wel_r;
      status_r.busy      <= !idle;
    end
  end

endmodule : snbe_core
`default_nettype wire

// *** sim/snbe_core_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module snbe_core_props #(
  parameter int ERASE_CYC = 20,
  parameter int REMAP_CYC = 10
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        spiClk,
  input wire logic        csN,
  input wire logic        serialIn,
  input wire logic        serialOut,
  input wire logic        serialOutEn,
  input wire logic        eccEnable,
  input wire logic        protect_top_bottom,
  input wire logic [3:0]  protect_level_bits,
  input wire logic        readDone,
  input wire logic [1:0]  readEccResult,
  input wire logic [15:0] readPage,
  input wire logic        markerValid,
  input wire logic [7:0]  markerMain,
  input wire logic [7:0]  markerSpare,
  input wire logic        badBlockMark,
  input wire logic        eccActive,
  input wire logic        eraseStart,
  input wire logic [9:0]  eraseBlock,
  input wire logic        busy,
  input wire logic        table_full_flag
);
  // ==========
  // helper: length of the running busy stretch
  logic [31:0] busyLen_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busyLen_r <= '0;
    else if (clkEn) busyLen_r <= busy ? busyLen_r + 32'h1 : '0;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // properties
  AST_ERASE_BUSY: assert property (eraseStart |=> !eraseStart && busy)
    else $error("erase start not followed by busy");
  // one cycle of slack either way: the stretch is counted on sampled busy
  AST_BUSY_LEN: assert property ($fell(busy) |->
    (busyLen_r >= REMAP_CYC - 1 && busyLen_r <= REMAP_CYC + 1) ||
    (busyLen_r >= ERASE_CYC - 1 && busyLen_r <= ERASE_CYC + 1))
    else $error("busy stretch of wrong length");
  AST_NO_START_BUSY: assert property (eraseStart |-> !$past(busy))
    else $error("erase started while busy");
  AST_FULL_HOLD: assert property (table_full_flag |=> table_full_flag)
    else $error("table full flag dropped");
  AST_FULL_NO_REMAP: assert property ($rose(busy) && $past(table_full_flag)
    |-> $past(eraseStart))
    else $error("remap accepted with full table");
  AST_PROT_SKIP: assert property (eraseStart |->
    protect_level_bits < 4'(snbe_pkg::PROT_ALL))
    else $error("erase started in protected array");
  AST_CS_QUIET: assert property (csN |-> !serialOutEn)
    else $error("output driven while deselected");
  AST_MARK_BAD: assert property (clkEn && markerValid &&
    (markerMain != 8'hff || markerSpare != 8'hff) |=> badBlockMark)
    else $error("bad marker missed");
  AST_MARK_GOOD: assert property (clkEn && markerValid &&
    markerMain == 8'hff && markerSpare == 8'hff |=> !badBlockMark)
    else $error("good block flagged bad");
  cover property (eraseStart);
  cover property ($rose(table_full_flag));
  cover property ($fell(busy));
  cover property ($rose(badBlockMark));
endmodule : snbe_core_props
bind snbe_core snbe_core_props #(.ERASE_CYC(ERASE_CYC),
  .REMAP_CYC(REMAP_CYC)) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .spiClk(spiClk),
  .csN(csN), .serialIn(serialIn), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .eccEnable(eccEnable),
  .protect_top_bottom(protect_top_bottom),
  .protect_level_bits(protect_level_bits), .readDone(readDone),
  .readEccResult(readEccResult), .readPage(readPage),
  .markerValid(markerValid), .markerMain(markerMain),
  .markerSpare(markerSpare), .badBlockMark(badBlockMark),
  .eccActive(eccActive), .eraseStart(eraseStart),
  .eraseBlock(eraseBlock), .busy(busy),
  .table_full_flag(table_full_flag));
`default_nettype wire

// *** sim/snbe_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module snbe_host (
  output var  logic spiClk,
  output var  logic csN,
  output var  logic serialIn,
  input  wire logic serialOut
);
  initial begin
    spiClk = 1'b0;
    csN = 1'b1;
    serialIn = 1'b0;
  end
  // ==========
  // mode 0 frame, 125 ns clock that stands low between frames
  task automatic frame(input logic [39:0] tx, input int nb,
                       output logic [639:0] rx);
    rx = '0;
    csN = 1'b0;
    #40;
    for (int i = 0; i < nb; i++) begin
      serialIn = (i < 40) ? tx[39-i] : 1'b0;
      #63;
      spiClk = 1'b1;
      if (i >= 16) rx = {rx[638:0], serialOut};
      #62;
      spiClk = 1'b0;
    end
    #40;
    csN = 1'b1;
    // released line shows no stale level
    serialIn = ~serialIn;
    #60;
  endtask : frame
endmodule : snbe_host
`default_nettype wire

// *** sim/snbe_core_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module snbe_core_tb;
  localparam int ERASE_CYC = 1500;
  localparam int REMAP_CYC = 40;
  logic sys_clk, rst_n, clkEn, spiClk, csN, serialIn, serialOut;
  logic serialOutEn, eccEnable, protect_top_bottom, readDone, busy;
  logic markerValid, badBlockMark, eccActive, eraseStart, table_full_flag;
  logic [3:0]   protect_level_bits;
  logic [1:0]   readEccResult;
  logic [15:0]  readPage;
  logic [7:0]   markerMain, markerSpare;
  logic [9:0]   eraseBlock, lastBlk;
  logic [639:0] rx;
  logic [31:0]  seed, r, starts, badCount, checksDone;
  logic [31:0]  links [20];
  snbe_core #(.ERASE_CYC(ERASE_CYC), .REMAP_CYC(REMAP_CYC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .spiClk(spiClk),
    .csN(csN), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .eccEnable(eccEnable),
    .protect_top_bottom(protect_top_bottom),
    .protect_level_bits(protect_level_bits), .readDone(readDone),
    .readEccResult(readEccResult), .readPage(readPage),
    .markerValid(markerValid), .markerMain(markerMain),
    .markerSpare(markerSpare), .badBlockMark(badBlockMark),
    .eccActive(eccActive), .eraseStart(eraseStart),
    .eraseBlock(eraseBlock), .busy(busy),
    .table_full_flag(table_full_flag));
  snbe_host i_host (.spiClk(spiClk), .csN(csN), .serialIn(serialIn),
    .serialOut(serialOut));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    starts = '0;
    lastBlk = '0;
  end
  always @(posedge sys_clk) begin
    if (eraseStart === 1'b1) begin
      starts++;
      lastBlk = eraseBlock;
    end
  end
  // ==========
  // checking and expectation helpers
  task automatic chkBit(input logic got, input logic exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBit
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord
  function automatic logic [31:0] linkExp(input logic [31:0] a);
    return {2'b10, a[29:0]};
  endfunction : linkExp
  function automatic logic [31:0] statExp(input logic f, input logic [1:0] e,
                                          input logic w, input logic b);
    return {24'h0, f, 1'b0, e, 2'b00, w, b};
  endfunction : statExp
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic cmd(input logic [39:0] tx, input int nb);
    i_host.frame(tx, nb, rx);
    tick(6);
  endtask : cmd
  // erase-skip bit b2 is masked: its clearing point is not pinned down
  task automatic status(input logic [7:0] op, input logic [31:0] exp);
    i_host.frame({op, 32'h0}, 24, rx);
    chkWord({24'h0, rx[7:0] & 8'hfb}, exp);
  endtask : status
  task automatic waitIdle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    chkBit(busy, 1'b0);
  endtask : waitIdle
  task automatic giveVerdict;
    $display("checks=%0d mismatches=%0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : giveVerdict
  initial begin
    #600000;
    badCount++;
    giveVerdict;
  end
  // ==========
  // main sequence
  initial begin
    seed = 32'h33f7b934;
    badCount = '0;
    checksDone = '0;
    {rst_n, readDone, markerValid, protect_top_bottom} = 4'h0;
    {clkEn, eccEnable} = 2'b11;
    {protect_level_bits, readEccResult, readPage} = '0;
    {markerMain, markerSpare} = 16'hffff;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    tick(2);
    chkBit(eccActive, 1'b1);
    status(snbe_pkg::OP_STAT_A, statExp(0, 2'b00, 0, 0));
    cmd({snbe_pkg::OP_REMAP, 32'h0001_0002}, 40);
    chkBit(busy, 1'b0);
    i_host.frame({snbe_pkg::OP_LUTRD, 32'h0}, 80, rx);
    chkWord(rx[63:32] | rx[31:0], 32'h0);
    cmd({snbe_pkg::OP_ERASE, 8'h00, 16'h0040, 8'h00}, 32);
    chkWord(starts, 32'h0);
    cmd({snbe_pkg::OP_WREN, 32'h0}, 8);
    status(snbe_pkg::OP_STAT_B, statExp(0, 2'b00, 1, 0));
    cmd({snbe_pkg::OP_WRDI, 32'h0}, 8);
    status(snbe_pkg::OP_STAT_A, statExp(0, 2'b00, 0, 0));
    cmd({snbe_pkg::OP_WREN, 32'h0}, 8);
    cmd({snbe_pkg::OP_ERASE, 8'h00, 16'h0080, 8'h00}, 33);
    chkWord(starts, 32'h0);
    r = $random(seed);
    cmd({snbe_pkg::OP_ERASE, 8'h00, r[15:0], 8'h00}, 32);
    chkWord(starts, 32'h1);
    chkWord({22'h0, lastBlk}, {22'h0, r[15:6]});
    chkBit(busy, 1'b1);
    cmd({snbe_pkg::OP_REMAP, 32'h0003_0004}, 40);
    status(snbe_pkg::OP_STAT_A, statExp(0, 2'b00, 1, 1));
    waitIdle;
    status(snbe_pkg::OP_STAT_A, statExp(0, 2'b00, 0, 0));
    // unique addresses on both sides keep the table well defined
    for (int k = 0; k < 20; k++) begin
      r = $random(seed);
      links[k] = {2'b00, 5'(k), r[24:16], 5'(k), r[10:0]};
      cmd({snbe_pkg::OP_WREN, 32'h0}, 8);
      chkBit(table_full_flag, 1'b0);
      cmd({snbe_pkg::OP_REMAP, links[k]}, 40);
      chkBit(busy, 1'b1);
      waitIdle;
    end
    status(snbe_pkg::OP_STAT_A, statExp(1, 2'b00, 0, 0));
    cmd({snbe_pkg::OP_WREN, 32'h0}, 8);
    cmd({snbe_pkg::OP_REMAP, 32'h0005_0006}, 40);
    chkBit(busy, 1'b0);
    status(snbe_pkg::OP_STAT_B, statExp(1, 2'b00, 1, 0));
    i_host.frame({snbe_pkg::OP_LUTRD, 32'h0}, 656, rx);
    for (int k = 0; k < 20; k++) begin
      chkWord(rx[639-32*k -: 32], linkExp(links[k]));
    end
    protect_level_bits = 4'(snbe_pkg::PROT_ALL);
    cmd({snbe_pkg::OP_ERASE, 8'h00, 16'h0100, 8'h00}, 32);
    chkWord(starts, 32'h1);
    {protect_top_bottom, protect_level_bits} = 5'h11;
    cmd({snbe_pkg::OP_ERASE, 8'h00, 16'hffc0, 8'h00}, 32);
    chkWord(starts, 32'h1);
    cmd({snbe_pkg::OP_ERASE, 8'h00, 16'h0140, 8'h00}, 32);
    chkWord({22'h0, lastBlk}, 32'h5);
    // clock enable low must freeze the erase timer
    clkEn = 1'b0;
    tick(1600);
    chkBit(busy, 1'b1);
    clkEn = 1'b1;
    waitIdle;
    r = $random(seed);
    {readDone, readEccResult, readPage} = {3'b110, r[15:0]};
    tick(1);
    readDone = 1'b0;
    tick(2);
    status(snbe_pkg::OP_STAT_A, statExp(1, 2'b10, 0, 0));
    i_host.frame({snbe_pkg::OP_FAILPG, 32'h0}, 32, rx);
    chkWord({16'h0, rx[15:0]}, {16'h0, r[15:0]});
    eccEnable = 1'b0;
    tick(2);
    chkBit(eccActive, 1'b0);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      markerMain = (k == 0) ? {1'b0, r[6:0]} : 8'hff;
      markerSpare = (k == 1) ? {1'b0, r[14:8]} : 8'hff;
      markerValid = 1'b1;
      tick(1);
      markerValid = 1'b0;
      tick(1);
      chkBit(badBlockMark, 1'(k != 2));
    end
    giveVerdict;
  end
endmodule : snbe_core_tb
`default_nettype wire
